// ---- design/asp_core.sv ----
// Full-duplex asynchronous serial port with byte register port.
// Assumes rxPin and txPinIn are asynchronous; the host drives the
// register strobes on clk, one at a time.
//
// Summary of operation
// - Status two writes touch two bits only
// - Break length 10/11, or 13/14 when long
// - Long break never alters receive framing
// - Pin direction bit matters in single-wire only
// - Low at first slot sets receiver active
// - Idle character clears receiver active
// - Data read is receive, write is transmit
// - High data bit7 received, bit6 transmitted ninth
// - Ninth transmit bit persists across frames
// - Independent directions sharing one baud generator
// - Start, eight or nine data, stop
// - Thirteen-bit divisor loads modulus counter
// - Receiver at divided clock, transmitter sixteenth
// - Sixteen receive slots per bit, three sampled
// - Baud tick synchronous to bus clock
// - Parity replaces character msb when enabled
// - Zero divisor stops; high byte waits low
// - Receive full cleared by status then read
`timescale 1ns/1ps
`default_nettype none
module asp_core (
  input  wire logic       clk,     // System clock, 100 MHz
  input  wire logic       rst_n,   // Sync reset
  input  wire logic       clkEn,   // Freezes all state when low
  input  wire logic [2:0] addr,    // Register offset
  input  wire logic [7:0] wrData,  // Write data
  input  wire logic       wrEn,    // Write strobe
  input  wire logic       rdEn,    // Read strobe
  output logic      [7:0] rdData,  // Read data, cycle after strobe
  input  wire logic       rxPin,   // Receive pin
  input  wire logic       txPinIn, // Transmit pin level seen
  output logic            txOut,   // Transmit pin drive value
  output logic            txOe_n   // Transmit pin enable, low drives
);
  typedef struct packed {
    logic              rxS1, rxS2, twS1, twS2;
    logic [7:0]        ctl;
    logic              longBrk, pinDir, receiver_active_flag;
    logic [4:0]        divHi;
    logic [12:0]       div;
    asp_pkg::asp_rx_e  rxSt;
    logic [3:0]        rxRt, rxBit;
    logic [8:0]        rxSh;
    logic [2:0]        smp;
    logic              rxNz;
    logic [8:0]        rxBuf;
    logic              rxFull, idleF, ovr, nz, frm, parErr, idleArm, rdArm;
    logic [7:0]        idleCnt;
    logic [3:0]        txPre, txLeft;
    logic [13:0]       txSh;
    logic [7:0]        txBuf;
    logic              t8, txFull, txCmpl, pre, brkTail, teLast;
    logic              txLine, txOeN;
    logic [7:0]        rdData;
  } asp_st_s;

  asp_st_s st_ff, nxt_st;
  logic    rtTick;
  logic    txTick;
  logic    rxLine;
  logic    brkLoad;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [3:0] frameLen(input logic m);
    frameLen = m ? asp_pkg::LEN_F9 : asp_pkg::LEN_F8;
  endfunction

  function automatic logic isAcc(input logic en, input logic [2:0] a,
                                 input logic [2:0] ofs);
    isAcc = en && (a == ofs);
  endfunction

  // ==========================================================
  // Shared baud generator
  asp_baud u_baud (
    .clk     (clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .divisor (st_ff.div),
    .rtTick  (rtTick)
  );

  assign txTick = rtTick && (st_ff.txPre == asp_pkg::SLOT_LAST);
  assign rxLine = st_ff.ctl[asp_pkg::CTL_ONEW] ? st_ff.twS2 : st_ff.rxS2;

  // ==========================================================
  // Next state
  always_comb begin
    logic        m, v, pOk;
    logic [8:0]  rxWord;
    logic [13:0] frame;
    logic [3:0]  slot;
    nxt_st  = st_ff;
    m       = st_ff.ctl[asp_pkg::CTL_FRAME9];
    v       = 1'b0;
    pOk     = 1'b0;
    rxWord  = '0;
    frame   = '1;
    slot    = st_ff.rxRt;
    brkLoad = 1'b0;
    nxt_st.rxS1 = rxPin;
    nxt_st.rxS2 = st_ff.rxS1;
    nxt_st.twS1 = txPinIn;
    nxt_st.twS2 = st_ff.twS1;

    // Register writes; they come first so later hardware updates override them
    if (wrEn) begin
      case (addr)
        asp_pkg::OFS_BAUD_HI: nxt_st.divHi = wrData[4:0];
        asp_pkg::OFS_BAUD_LO: nxt_st.div = {st_ff.divHi, wrData};
        asp_pkg::OFS_CTRL:    nxt_st.ctl = wrData;
        asp_pkg::OFS_STAT2: begin
          nxt_st.longBrk = wrData[asp_pkg::S2_LONGBRK];
          nxt_st.pinDir  = wrData[asp_pkg::S2_PINDIR];
        end
        asp_pkg::OFS_DATA_HI: nxt_st.t8 = wrData[asp_pkg::DH_TX9];
        asp_pkg::OFS_DATA_LO: begin
          nxt_st.txBuf  = wrData;
          nxt_st.txFull = 1'b1;
          nxt_st.txCmpl = 1'b0;
        end
        default: ;
      endcase
    end

    // Register reads; unmapped offsets read zero
    nxt_st.rdData = 8'h00;
    if (rdEn) begin
      case (addr)
        asp_pkg::OFS_BAUD_HI: nxt_st.rdData = {3'h0, st_ff.div[12:8]};
        asp_pkg::OFS_BAUD_LO: nxt_st.rdData = st_ff.div[7:0];
        asp_pkg::OFS_CTRL:    nxt_st.rdData = st_ff.ctl;
        asp_pkg::OFS_STAT1: begin
          nxt_st.rdData = {!st_ff.txFull, st_ff.txCmpl, st_ff.rxFull, st_ff.idleF,
                           st_ff.ovr, st_ff.nz, st_ff.frm, st_ff.parErr};
          nxt_st.rdArm  = 1'b1;
        end
        asp_pkg::OFS_STAT2:
          nxt_st.rdData = {5'h00, st_ff.longBrk, st_ff.pinDir, st_ff.receiver_active_flag};
        asp_pkg::OFS_DATA_HI:
          nxt_st.rdData = {st_ff.rxBuf[8], st_ff.t8, 6'h00};
        asp_pkg::OFS_DATA_LO: begin
          nxt_st.rdData = st_ff.rxBuf[7:0];
          if (st_ff.rdArm) begin
            nxt_st.rxFull = 1'b0;
            nxt_st.idleF  = 1'b0;
            nxt_st.ovr    = 1'b0;
            nxt_st.nz     = 1'b0;
            nxt_st.frm    = 1'b0;
            nxt_st.parErr = 1'b0;
          end
          nxt_st.rdArm = 1'b0;
        end
        default: ;
      endcase
    end

    // ==========================================================
    // Receiver, 16 slots per bit
    if (rtTick) begin
      case (st_ff.rxSt)
        asp_pkg::RX_IDLE: begin
          if (!rxLine && st_ff.ctl[asp_pkg::CTL_RX_EN] && !st_ff.frm) begin
            nxt_st.receiver_active_flag   = 1'b1;
            nxt_st.rxSt  = asp_pkg::RX_START;
            nxt_st.rxRt  = 4'h1;
            nxt_st.rxBit = 4'h0;
            nxt_st.rxNz  = 1'b0;
          end
          if (!rxLine) begin
            nxt_st.idleCnt = 8'h00;
          end else if (st_ff.idleCnt == {frameLen(m), 4'h0}) begin
            nxt_st.receiver_active_flag     = 1'b0;
            nxt_st.idleF   = st_ff.idleF | st_ff.idleArm;
            nxt_st.idleArm = 1'b0;
            nxt_st.idleCnt = st_ff.idleCnt + 8'h01;
          end else if (st_ff.idleCnt != 8'hff) begin
            nxt_st.idleCnt = st_ff.idleCnt + 8'h01;
          end
        end
        asp_pkg::RX_START, asp_pkg::RX_DATA, asp_pkg::RX_STOP: begin
          nxt_st.rxRt = slot + 4'h1;
          if (slot == asp_pkg::SMP_A || slot == asp_pkg::SMP_B) begin
            nxt_st.smp = {st_ff.smp[1:0], rxLine};
          end
          if (slot == asp_pkg::SMP_C) begin
            v = maj3({st_ff.smp[1:0], rxLine});
            if (st_ff.smp[1:0] != {2{rxLine}}) begin
              nxt_st.rxNz = 1'b1;
            end
            if (st_ff.rxSt == asp_pkg::RX_START && v) begin
              nxt_st.rxSt = asp_pkg::RX_IDLE;
              nxt_st.receiver_active_flag  = 1'b0;
            end else if (st_ff.rxSt == asp_pkg::RX_DATA) begin
              nxt_st.rxSh  = {v, st_ff.rxSh[8:1]};
              nxt_st.rxBit = st_ff.rxBit + 4'h1;
            end else if (st_ff.rxSt == asp_pkg::RX_STOP) begin
              rxWord = m ? st_ff.rxSh : {1'b0, st_ff.rxSh[8:1]};
              pOk    = (^rxWord) == st_ff.ctl[asp_pkg::CTL_PAR_OD];
              nxt_st.rxSt    = asp_pkg::RX_IDLE;
              nxt_st.idleCnt = 8'h00;
              if (st_ff.rxFull) begin
                nxt_st.ovr = 1'b1;
              end else begin
                // Break yields all zeros, so the buffer reads cleared
                nxt_st.rxBuf   = rxWord;
                nxt_st.rxFull  = 1'b1;
                nxt_st.frm     = !v;
                nxt_st.nz      = st_ff.rxNz || (st_ff.smp[1:0] != {2{rxLine}});
                nxt_st.parErr  = st_ff.ctl[asp_pkg::CTL_PAR_EN] && !pOk;
                nxt_st.idleArm = 1'b1;
              end
            end
          end
          if (slot == asp_pkg::SLOT_LAST) begin
            if (st_ff.rxSt == asp_pkg::RX_START) begin
              nxt_st.rxSt = asp_pkg::RX_DATA;
            end else if (st_ff.rxSt == asp_pkg::RX_DATA &&
                         st_ff.rxBit == (m ? asp_pkg::BITS9 : asp_pkg::BITS8)) begin
              nxt_st.rxSt = asp_pkg::RX_STOP;
            end
          end
        end
        default: nxt_st.rxSt = asp_pkg::RX_IDLE;
      endcase
    end

    // ==========================================================
    // Transmitter, one bit per 16 baud ticks
    nxt_st.teLast = st_ff.ctl[asp_pkg::CTL_TX_EN];
    if (st_ff.ctl[asp_pkg::CTL_TX_EN] && !st_ff.teLast) begin
      nxt_st.pre = 1'b1;
    end
    if (rtTick) begin
      nxt_st.txPre = st_ff.txPre + 4'h1;
    end
    if (txTick) begin
      if (st_ff.txLeft > 4'h1) begin
        nxt_st.txSh   = {1'b1, st_ff.txSh[13:1]};
        nxt_st.txLeft = st_ff.txLeft - 4'h1;
      end else if (st_ff.ctl[asp_pkg::CTL_TX_EN] && st_ff.ctl[asp_pkg::CTL_BRK]) begin
        brkLoad        = 1'b1;
        nxt_st.txSh    = '0;
        nxt_st.txLeft  = st_ff.longBrk ? (m ? asp_pkg::LEN_LB9 : asp_pkg::LEN_LB8)
                                       : frameLen(m);
        nxt_st.brkTail = 1'b1;
        nxt_st.txCmpl  = 1'b0;
      end else if (st_ff.brkTail || (st_ff.pre && st_ff.ctl[asp_pkg::CTL_TX_EN])) begin
        // A break always ends with at least one high bit
        nxt_st.txSh    = '1;
        nxt_st.txLeft  = st_ff.brkTail ? 4'h1 : frameLen(m);
        nxt_st.brkTail = 1'b0;
        nxt_st.pre     = st_ff.brkTail && st_ff.pre;
        nxt_st.txCmpl  = 1'b0;
      end else if (st_ff.ctl[asp_pkg::CTL_TX_EN] && st_ff.txFull) begin
        if (m) begin
          frame = {3'h7, 1'b1, st_ff.ctl[asp_pkg::CTL_PAR_EN] ?
                   (st_ff.ctl[asp_pkg::CTL_PAR_OD] ^ (^st_ff.txBuf)) : st_ff.t8,
                   st_ff.txBuf, 1'b0};
        end else begin
          frame = {4'hf, 1'b1, st_ff.ctl[asp_pkg::CTL_PAR_EN] ?
                   (st_ff.ctl[asp_pkg::CTL_PAR_OD] ^ (^st_ff.txBuf[6:0])) : st_ff.txBuf[7],
                   st_ff.txBuf[6:0], 1'b0};
        end
        nxt_st.txSh   = frame;
        nxt_st.txLeft = frameLen(m);
        nxt_st.txFull = 1'b0;
        nxt_st.txCmpl = 1'b0;
      end else begin
        nxt_st.txLeft = 4'h0;
        // Clear wins when a data write lands on the same tick
        nxt_st.txCmpl = !nxt_st.txFull;
      end
    end
    nxt_st.txLine = (nxt_st.txLeft == 4'h0) ? 1'b1 : nxt_st.txSh[0];
    if (st_ff.ctl[asp_pkg::CTL_ONEW]) begin
      nxt_st.txOeN = !st_ff.pinDir;
    end else begin
      nxt_st.txOeN = !(st_ff.ctl[asp_pkg::CTL_TX_EN] || nxt_st.txLeft != 4'h0);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff        <= '0;
      st_ff.ctl    <= asp_pkg::CTL_RESET;
      st_ff.div    <= asp_pkg::DIV_RESET;
      st_ff.rxSt   <= asp_pkg::RX_IDLE;
      st_ff.txCmpl <= 1'b1;
      st_ff.txLine <= 1'b1;
      st_ff.txOeN  <= 1'b1;
      st_ff.rxS1   <= 1'b1;
      st_ff.rxS2   <= 1'b1;
      st_ff.twS1   <= 1'b1;
      st_ff.twS2   <= 1'b1;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  assign rdData = st_ff.rdData;
  assign txOut  = st_ff.txLine;
  assign txOe_n = st_ff.txOeN;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_stat2_write_mask: assert property (
    clkEn && isAcc(wrEn, addr, asp_pkg::OFS_STAT2)
    |=> st_ff.longBrk == $past(wrData[asp_pkg::S2_LONGBRK])
        && st_ff.pinDir == $past(wrData[asp_pkg::S2_PINDIR]))
    else $error("status two write mismatch");
  a_break_length: assert property (
    clkEn && brkLoad |=> st_ff.txLeft == ($past(st_ff.longBrk)
      ? ($past(st_ff.ctl[asp_pkg::CTL_FRAME9]) ? asp_pkg::LEN_LB9 : asp_pkg::LEN_LB8)
      : ($past(st_ff.ctl[asp_pkg::CTL_FRAME9]) ? asp_pkg::LEN_F9 : asp_pkg::LEN_F8)))
    else $error("break length wrong");
  a_raf_on_start: assert property (
    clkEn && rtTick && st_ff.rxSt == asp_pkg::RX_IDLE && !rxLine
    && st_ff.ctl[asp_pkg::CTL_RX_EN] && !st_ff.frm
    |=> st_ff.receiver_active_flag && st_ff.rxSt == asp_pkg::RX_START)
    else $error("receiver active not set");
  a_t8_holds: assert property (
    !(wrEn && addr == asp_pkg::OFS_DATA_HI) |=> $stable(st_ff.t8))
    else $error("ninth transmit bit changed");
  a_read_low: assert property (
    clkEn && isAcc(rdEn, addr, asp_pkg::OFS_DATA_LO)
    |=> rdData == $past(st_ff.rxBuf[7:0]))
    else $error("data low read wrong");
  a_read_high: assert property (
    clkEn && isAcc(rdEn, addr, asp_pkg::OFS_DATA_HI)
    |=> rdData[asp_pkg::DH_RX9] == $past(st_ff.rxBuf[8])
        && rdData[asp_pkg::DH_TX9] == $past(st_ff.t8))
    else $error("data high read wrong");
  a_div_zero_quiet: assert property (
    st_ff.div == asp_pkg::DIV_RESET && $past(st_ff.div) == asp_pkg::DIV_RESET |-> !rtTick)
    else $error("baud tick with zero divisor");
  a_tx_idle_high: assert property (
    st_ff.txLeft == 4'h0 |-> txOut)
    else $error("idle line not high");
  a_tx_bit_pace: assert property (
    clkEn && !txTick |=> $stable(st_ff.txSh) && $stable(st_ff.txLeft))
    else $error("transmit shifted off its tick");

  c_break_sent:   cover property (brkLoad);
  c_frame_rx:     cover property (st_ff.rxFull && !$past(st_ff.rxFull));
  c_overrun:      cover property (st_ff.ovr);
  c_idle_flag:    cover property (st_ff.idleF);
endmodule // asp_core
`default_nettype wire

// ---- design/asp_pkg.sv ----
// Constants, register map and state codes of the serial port core.
// Assumes a byte-wide register port with a 3-bit address.
package asp_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [2:0] OFS_BAUD_HI = 3'h0;
  localparam logic [2:0] OFS_BAUD_LO = 3'h1;
  localparam logic [2:0] OFS_CTRL    = 3'h2;
  localparam logic [2:0] OFS_STAT1   = 3'h4;
  localparam logic [2:0] OFS_STAT2   = 3'h5;
  localparam logic [2:0] OFS_DATA_HI = 3'h6;
  localparam logic [2:0] OFS_DATA_LO = 3'h7;
  // ==========================================================
  // Field positions
  localparam int CTL_FRAME9 = 0;
  localparam int CTL_PAR_EN = 1;
  localparam int CTL_PAR_OD = 2;
  localparam int CTL_TX_EN  = 3;
  localparam int CTL_RX_EN  = 4;
  localparam int CTL_BRK    = 5;
  localparam int CTL_ONEW   = 6;
  localparam int S2_LONGBRK = 2;
  localparam int S2_PINDIR  = 1;
  localparam int DH_RX9     = 7;
  localparam int DH_TX9     = 6;
  // ==========================================================
  // Reset values and timing
  localparam logic [12:0] DIV_RESET = 13'h0000;
  localparam logic [7:0]  CTL_RESET = 8'h00;
  localparam logic [3:0]  SLOT_LAST = 4'hf;
  localparam logic [3:0]  SMP_A     = 4'h8;
  localparam logic [3:0]  SMP_B     = 4'h9;
  localparam logic [3:0]  SMP_C     = 4'ha;
  localparam logic [3:0]  LEN_F8    = 4'ha;
  localparam logic [3:0]  LEN_F9    = 4'hb;
  localparam logic [3:0]  LEN_LB8   = 4'hd;
  localparam logic [3:0]  LEN_LB9   = 4'he;
  localparam logic [3:0]  BITS8     = 4'h8;
  localparam logic [3:0]  BITS9     = 4'h9;
  // ==========================================================
  // Receiver states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } asp_rx_e;
endpackage

// ---- design/asp_baud.sv ----
// Baud modulus counter: one tick every divisor clocks.
// Assumes the divisor only changes as a whole 13-bit word.
`timescale 1ns/1ps
`default_nettype none
module asp_baud (
  input  wire logic        clk,     // System clock
  input  wire logic        rst_n,   // Sync reset
  input  wire logic        clkEn,   // Clock enable
  input  wire logic [12:0] divisor, // Modulus
  output logic             rtTick   // Sample tick
);
  typedef struct packed {
    logic [12:0] cnt;
    logic        tick;
  } asp_bd_s;

  asp_bd_s st_ff, nxt_st;

  // ==========================================================
  // Counter
  // Tick is an enable in the bus domain, not a clock
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (divisor == asp_pkg::DIV_RESET) begin
      nxt_st.cnt = asp_pkg::DIV_RESET;
    end else if (st_ff.cnt >= divisor - 13'h0001) begin
      nxt_st.cnt  = asp_pkg::DIV_RESET;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  assign rtTick = st_ff.tick;
endmodule // asp_baud
`default_nettype wire

// ---- test/asp_remote.sv ----
// Remote serial device model facing the core's line pins.
// Assumes it shares the core clock and a fixed bit time in clocks.
`timescale 1ns/1ps
`default_nettype none
module asp_remote #(
  parameter int BIT_CLKS = 48  // Clocks per bit
) (
  input  wire logic clk,    // Shared clock
  input  wire logic txLine, // Core transmit pin level
  output logic      rxLine  // Core receive pin drive
);
  // Idle line is a mark, same as the pull-up level
  initial rxLine = 1'b1;

  // ==========================================================
  // Frame sender, start low, data lsb first, chosen stop level
  task automatic sendFrame(input logic [8:0] d, input int nData, input logic stopBit);
    rxLine <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nData; i++) begin
      rxLine <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxLine <= stopBit;
    repeat (BIT_CLKS) @(posedge clk);
    rxLine <= 1'b1;
  endtask

  // ==========================================================
  // Frame receiver, samples mid-bit after the start edge
  task automatic recvFrame(input int nData, output logic [8:0] d, output logic stopBit,
                           output bit ok);
    int n;
    n = 0;
    d = 9'h000;
    while (txLine !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 40000);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < nData; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      d[i] = txLine;
    end
    repeat (BIT_CLKS) @(posedge clk);
    stopBit = txLine;
  endtask
endmodule // asp_remote
`default_nettype wire

// ---- test/async_serial_port_core_bench.sv ----
// Self-checking bench for the serial port core with a remote partner.
// Assumes the core's register map and a divisor of DIV clocks.
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_core_bench;
  localparam int DIV = 3;
  localparam int BIT = 16 * DIV;
  logic       clk;
  logic       rst_n;
  logic       clkEn;
  logic [2:0] addr;
  logic [7:0] wrData;
  logic       wrEn;
  logic       rdEn;
  logic [7:0] rdData;
  logic       rxPin;
  logic       txOut;
  logic       txOe_n;
  logic       txPinIn;
  logic [7:0] v;
  int         failCount;
  int         nCompared;

  // Pulled-up pin: reads high when the core releases it
  assign txPinIn = txOe_n ? 1'b1 : txOut;

  asp_core dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .addr(addr), .wrData(wrData),
                .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rxPin(rxPin),
                .txPinIn(txPinIn), .txOut(txOut), .txOe_n(txOe_n));
  asp_remote #(.BIT_CLKS(BIT)) remote (.clk(clk), .txLine(txOut), .rxLine(rxPin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Bus and checking helpers
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic end_sim();
    if (failCount == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic tReset();
    settle();
    chk("txIdle", {txOut, txOe_n}, 2'b11);
    rd(asp_pkg::OFS_DATA_HI, v);
    chk("dataHiRst", v, 8'h00);
    rd(asp_pkg::OFS_DATA_LO, v);
    chk("dataLoRst", v, 8'h00);
    rd(asp_pkg::OFS_STAT2, v);
    chk("stat2Rst", v, 8'h00);
  endtask

  task automatic tStat2();
    wr(asp_pkg::OFS_STAT2, 8'hff);
    rd(asp_pkg::OFS_STAT2, v);
    chk("stat2Set", v, 8'h06);
    wr(asp_pkg::OFS_STAT2, 8'h00);
    rd(asp_pkg::OFS_STAT2, v);
    chk("stat2Clr", v, 8'h00);
  endtask

  task automatic tFreeze();
    @(posedge clk);
    clkEn <= 1'b0;
    wr(asp_pkg::OFS_STAT2, 8'h06);
    clkEn <= 1'b1;
    rd(asp_pkg::OFS_STAT2, v);
    chk("frozenWrite", v, 8'h00);
  endtask

  task automatic tPinDir();
    wr(asp_pkg::OFS_CTRL, 8'h40);
    wr(asp_pkg::OFS_STAT2, 8'h02);
    settle();
    chk("oeOut", txOe_n, 1'b0);
    wr(asp_pkg::OFS_STAT2, 8'h00);
    settle();
    chk("oeIn", txOe_n, 1'b1);
    wr(asp_pkg::OFS_CTRL, 8'h00);
    settle();
    wr(asp_pkg::OFS_STAT2, 8'h02);
    settle();
    chk("oeOff", txOe_n, 1'b1);
    wr(asp_pkg::OFS_STAT2, 8'h00);
  endtask

  task automatic tTx8();
    logic [8:0] d;
    logic sb;
    bit ok;
    int n;
    n = 0;
    wr(asp_pkg::OFS_CTRL, 8'h18);
    wr(asp_pkg::OFS_DATA_LO, 8'h5a);
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (txOut !== 1'b1) n++;
    end
    chk("zeroDivHold", n, 0);
    wr(asp_pkg::OFS_BAUD_HI, 8'h00);
    wr(asp_pkg::OFS_BAUD_LO, 8'(DIV));
    fork
      remote.recvFrame(8, d, sb, ok);
      begin
        repeat (300) @(posedge clk);
        remote.sendFrame(9'h0c3, 8, 1'b1);
      end
    join
    chk("tx8", {ok, sb, d[7:0]}, {2'b11, 8'h5a});
    rd(asp_pkg::OFS_STAT1, v);
    chk("rxFullSet", v[5], 1'b1);
    rd(asp_pkg::OFS_DATA_LO, v);
    chk("duplexRx", v, 8'hc3);
  endtask

  task automatic tTx9();
    logic [8:0] d;
    logic sb;
    bit ok;
    wr(asp_pkg::OFS_CTRL, 8'h19);
    wr(asp_pkg::OFS_DATA_HI, 8'hc0);
    wr(asp_pkg::OFS_DATA_LO, 8'ha5);
    remote.recvFrame(9, d, sb, ok);
    chk("tx9a", {ok, sb, d}, {2'b11, 9'h1a5});
    wr(asp_pkg::OFS_DATA_LO, 8'h3c);
    remote.recvFrame(9, d, sb, ok);
    chk("tx9b", {ok, sb, d}, {2'b11, 9'h13c});
  endtask

  // Even parity both ways: sent msb becomes parity, odd-weight receive flags
  task automatic tParity();
    logic [8:0] d;
    logic       sb;
    bit         ok;
    wr(asp_pkg::OFS_CTRL, 8'h1a);
    wr(asp_pkg::OFS_DATA_LO, 8'h07);
    fork
      remote.recvFrame(8, d, sb, ok);
      begin
        repeat (300) @(posedge clk);
        remote.sendFrame(9'h007, 8, 1'b1);
      end
    join
    chk("txParity", {ok, sb, d[7:0]}, {2'b11, 8'h87});
    rd(asp_pkg::OFS_STAT1, v);
    chk("rxParErr", v & 8'h21, 8'h21);
    rd(asp_pkg::OFS_DATA_LO, v);
    chk("rxParData", v, 8'h07);
  endtask

  task automatic tRx(input logic [8:0] d, input int nb, input logic stopB, input logic lb);
    wr(asp_pkg::OFS_STAT2, {5'h00, lb, 2'b00});
    wr(asp_pkg::OFS_CTRL, (nb == 9) ? 8'h19 : 8'h18);
    fork
      remote.sendFrame(d, nb, stopB);
      begin
        repeat (BIT / 2) @(posedge clk);
        rd(asp_pkg::OFS_STAT2, v);
        chk("rxActive", v[0], 1'b1);
      end
    join
    repeat (4) @(posedge clk);
    rd(asp_pkg::OFS_STAT1, v);
    chk("rxFlags", v & 8'h22, {2'b00, 1'b1, 3'b000, ~stopB, 1'b0});
    rd(asp_pkg::OFS_DATA_HI, v);
    if (nb == 9) chk("rxNinth", v[7], d[8]);
    rd(asp_pkg::OFS_DATA_LO, v);
    chk("rxData", v, d[7:0]);
    rd(asp_pkg::OFS_STAT1, v);
    chk("rxFullClr", v[5], 1'b0);
    repeat ((nb + 3) * BIT) @(posedge clk);
    rd(asp_pkg::OFS_STAT2, v);
    chk("rxIdle", v[0], 1'b0);
  endtask

  task automatic tBreak();
    int n;
    int want;
    for (int k = 0; k < 4; k++) begin
      wr(asp_pkg::OFS_STAT2, {5'h00, k[1], 2'b00});
      wr(asp_pkg::OFS_CTRL, {7'h1c, k[0]});
      n = 0;
      while (txOut !== 1'b0 && n < 4000) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 4000) begin
        failCount++;
        end_sim();
      end
      n = 0;
      fork
        wr(asp_pkg::OFS_CTRL, {7'h0c, k[0]});
        do begin
          @(posedge clk);
          #1;
          n++;
        end while (txOut === 1'b0 && n < 1000);
      join
      want = (k[0] ? 11 : 10) + (k[1] ? 3 : 0);
      chk("breakLen", n, want * BIT);
      repeat (2 * BIT) @(posedge clk);
    end
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    failCount = 0;
    nCompared = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    addr = 3'h0;
    wrData = 8'h00;
    wrEn = 1'b0;
    rdEn = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    tReset();
    tStat2();
    tFreeze();
    tPinDir();
    tTx8();
    tTx9();
    tParity();
    tRx(9'h05a, 8, 1'b1, 1'b0);
    tRx(9'h1c3, 9, 1'b1, 1'b1);
    tRx(9'h000, 8, 1'b0, 1'b0);
    tRx(9'h000, 8, 1'b0, 1'b1);
    tBreak();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failCount++;
    end_sim();
  end
endmodule // async_serial_port_core_bench
`default_nettype wire
